// ==== hw/saf_core.sv ====
// The register offsets and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
`include "saf_core_regs.svh"

// What this block does
// - result is file value minus accumulator
// - decode opcode 010111, dest, bank, location
// - dest zero writes accumulator, file untouched
// - dest one writes result to file
// - bank bit zero uses common window bank
// - bank bit one uses bank pointer
// - extended mode, bank bit zero: location up to 95 indexed
// - four cycles, one per phase: decode, read, compute, write
module saf_core #(
  parameter int BANKS = 4  // number of general_file_bank pages
) (
  input wire logic clk,                    // 200 mhz core clock
  input wire logic rst,                    // async reset, active high
  input wire logic [4:0] avs_address,      // byte address
  input wire logic avs_read,               // read request
  input wire logic avs_write,              // write request
  input wire logic [31:0] avs_writedata,   // write data
  input wire logic [3:0] avs_byteenable,   // byte lanes
  output logic [31:0] avs_readdata,        // registered read data
  output logic avs_waitrequest             // stall, combinational
);

  localparam int AW = $clog2(BANKS * 256);  // data memory address width
  localparam int BW = AW - 8;               // bank pointer width

  // register state
  logic ack_q, ack_d;                       // second cycle of an access
  logic [31:0] rdata_q, rdata_d;            // read data
  logic ext_q, ext_d;                       // extended set enabled
  logic [15:0] insn_q, insn_d;              // instruction word
  logic [7:0] acc_q, acc_d;                 // accumulator
  logic [BW-1:0] bank_q, bank_d;            // bank_pointer
  saf_pkg::saf_flags_t flags_q, flags_d;    // status flags
  saf_pkg::saf_flags_t calc_q, calc_d;      // flags from the q3 phase
  logic bad_q, bad_d;                       // last word was not ours
  logic [AW-1:0] index_q, index_d;          // indexed offset base
  logic [AW-1:0] maddr_q, maddr_d;          // memory window pointer
  logic [AW-1:0] addr_q, addr_d;            // operand address
  logic [7:0] opnd_q, opnd_d;               // operand read in q2
  logic [7:0] res_q, res_d;                 // result from q3
  saf_pkg::saf_state_t state_q, state_d;    // phase
  logic [7:0] mem_q [BANKS*256];            // data memory
  logic mem_we;                             // memory write strobe
  logic [AW-1:0] mem_wa;                    // memory write address
  logic [7:0] mem_wd;                       // memory write data

  // helpers
  saf_pkg::saf_insn_t insn;                 // decoded instruction
  logic req, busy, wr_do;                   // bus qualifiers
  logic [8:0] diff9;                        // full borrow subtract
  logic [4:0] diff5;                        // low nibble subtract

  assign insn = saf_pkg::saf_insn_t'(insn_q);
  assign req = avs_read | avs_write;
  assign busy = state_q != saf_pkg::st_idle;
  assign wr_do = avs_write & ack_q;
  assign avs_waitrequest = req & (busy | ~ack_q);
  assign avs_readdata = rdata_q;
  assign diff9 = {1'b0, opnd_q} - {1'b0, acc_q};
  assign diff5 = {1'b0, opnd_q[3:0]} - {1'b0, acc_q[3:0]};

  // effective address of the operand
  function automatic logic [AW-1:0] eff_addr(
    input saf_pkg::saf_insn_t i,
    input logic ext,
    input logic [BW-1:0] bank,
    input logic [AW-1:0] index
  );
    logic [AW-1:0] a;
    a = {bank, i.f};
    if (!i.bank_sel) begin
      // common window: low half bank 0, high half top bank
      if (i.f < `SAF_ACC_SPLIT) begin
        a = {{BW{1'b0}}, i.f};
      end else begin
        a = {{BW{1'b1}}, i.f};
      end
      // indexed literal offset when extended set is on
      if (ext && i.f <= `SAF_ILO_MAX) begin
        a = index + {{BW{1'b0}}, i.f};
      end
    end
    return a;
  endfunction : eff_addr

  // next values: bus slave, registers and instruction phases
  always_comb begin
    ack_d = req & ~busy & ~ack_q;
    rdata_d = rdata_q;
    ext_d = ext_q;
    insn_d = insn_q;
    acc_d = acc_q;
    bank_d = bank_q;
    flags_d = flags_q;
    calc_d = calc_q;
    bad_d = bad_q;
    index_d = index_q;
    maddr_d = maddr_q;
    addr_d = addr_q;
    opnd_d = opnd_q;
    res_d = res_q;
    state_d = state_q;
    mem_we = 1'b0;
    mem_wa = maddr_q;
    mem_wd = avs_writedata[7:0];
    // read data is captured in the first cycle of a read
    if (avs_read && ack_d) begin
      rdata_d = 32'h0000_0000;
      unique case (avs_address)
        `SAF_OFF_CTRL: rdata_d[`SAF_CTRL_EXT] = ext_q;
        `SAF_OFF_INSN: rdata_d[15:0] = insn_q;
        `SAF_OFF_ACC: rdata_d[7:0] = acc_q;
        `SAF_OFF_BANK: rdata_d[BW-1:0] = bank_q;
        `SAF_OFF_STATUS: begin
          rdata_d[4:0] = flags_q;
          rdata_d[`SAF_ST_BUSY] = busy;
          rdata_d[`SAF_ST_BAD] = bad_q;
        end
        `SAF_OFF_INDEX: rdata_d[AW-1:0] = index_q;
        `SAF_OFF_MADDR: rdata_d[AW-1:0] = maddr_q;
        `SAF_OFF_MDATA: rdata_d[7:0] = mem_q[maddr_q];
        default: rdata_d = 32'h0000_0000;  // unmapped reads zero
      endcase
    end
    // writes take effect on the edge that samples waitrequest low
    if (wr_do && avs_byteenable[0]) begin
      unique case (avs_address)
        `SAF_OFF_CTRL: begin
          ext_d = avs_writedata[`SAF_CTRL_EXT];
          if (avs_writedata[`SAF_CTRL_GO]) begin
            state_d = saf_pkg::st_q1;
          end
        end
        `SAF_OFF_INSN: begin
          insn_d[7:0] = avs_writedata[7:0];
          if (avs_byteenable[1]) begin
            insn_d[15:8] = avs_writedata[15:8];
          end
        end
        `SAF_OFF_ACC: acc_d = avs_writedata[7:0];
        `SAF_OFF_BANK: bank_d = avs_writedata[BW-1:0];
        `SAF_OFF_STATUS: begin
          flags_d = saf_pkg::saf_flags_t'(avs_writedata[4:0]);
          // bad flag is write one to clear
          if (avs_writedata[`SAF_ST_BAD]) begin
            bad_d = 1'b0;
          end
        end
        `SAF_OFF_INDEX: index_d = avs_writedata[AW-1:0];
        `SAF_OFF_MADDR: maddr_d = avs_writedata[AW-1:0];
        `SAF_OFF_MDATA: mem_we = 1'b1;
        default: ;  // unmapped writes are dropped
      endcase
    end
    // instruction phases, one per clock
    unique case (state_q)
      saf_pkg::st_idle: ;
      saf_pkg::st_q1: begin
        // decode: reject any other opcode
        if (insn.op != `SAF_OPCODE) begin
          bad_d = 1'b1;
          state_d = saf_pkg::st_idle;
        end else begin
          addr_d = eff_addr(insn, ext_q, bank_q, index_q);
          state_d = saf_pkg::st_q2;
        end
      end
      saf_pkg::st_q2: begin
        // read the file register
        opnd_d = mem_q[addr_q];
        state_d = saf_pkg::st_q3;
      end
      saf_pkg::st_q3: begin
        // compute result and flags
        res_d = diff9[7:0];
        calc_d.c = ~diff9[8];
        calc_d.z = diff9[7:0] == 8'h00;
        calc_d.n = diff9[7];
        calc_d.nib = ~diff5[4];
        calc_d.rng = (opnd_q[7] ^ acc_q[7]) & (diff9[7] ^ opnd_q[7]);
        state_d = saf_pkg::st_q4;
      end
      saf_pkg::st_q4: begin
        // write destination and the five flags
        if (insn.dest) begin
          mem_we = 1'b1;
          mem_wa = addr_q;
          mem_wd = res_q;
        end else begin
          acc_d = res_q;
        end
        flags_d = calc_q;
        state_d = saf_pkg::st_idle;
      end
    endcase
  end

  // control registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      ext_q <= 1'b0;
      insn_q <= `SAF_RST_INSN;
      acc_q <= `SAF_RST_BYTE;
      bank_q <= '0;
      flags_q <= '0;
      calc_q <= '0;
      bad_q <= 1'b0;
      index_q <= '0;
      maddr_q <= '0;
      addr_q <= '0;
      opnd_q <= `SAF_RST_BYTE;
      res_q <= `SAF_RST_BYTE;
      state_q <= saf_pkg::st_idle;
    end else begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      ext_q <= ext_d;
      insn_q <= insn_d;
      acc_q <= acc_d;
      bank_q <= bank_d;
      flags_q <= flags_d;
      calc_q <= calc_d;
      bad_q <= bad_d;
      index_q <= index_d;
      maddr_q <= maddr_d;
      addr_q <= addr_d;
      opnd_q <= opnd_d;
      res_q <= res_d;
      state_q <= state_d;
    end
  end

  // data memory
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < BANKS * 256; k++) begin
        mem_q[k] <= `SAF_RST_BYTE;
      end
    end else if (mem_we) begin
      mem_q[mem_wa] <= mem_wd;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  phase_seq_a: assert property (
    state_q == saf_pkg::st_q1 && insn.op == `SAF_OPCODE |=>
    state_q == saf_pkg::st_q2 ##1 state_q == saf_pkg::st_q3
    ##1 state_q == saf_pkg::st_q4 ##1 state_q == saf_pkg::st_idle)
    else $error("instruction phases out of order");

  bad_opcode_a: assert property (
    state_q == saf_pkg::st_q1 && insn.op != `SAF_OPCODE |=>
    state_q == saf_pkg::st_idle && bad_q)
    else $error("foreign opcode not rejected");

  acc_dest_a: assert property (
    state_q == saf_pkg::st_q4 && !insn.dest |=>
    acc_q == $past(res_q) && mem_q[addr_q] == $past(mem_q[addr_q]))
    else $error("accumulator destination wrong");

  file_dest_a: assert property (
    state_q == saf_pkg::st_q4 && insn.dest |=>
    mem_q[addr_q] == $past(res_q) && $stable(acc_q))
    else $error("file destination wrong");

  common_bank_a: assert property (
    state_q == saf_pkg::st_q1 && insn.op == `SAF_OPCODE &&
    !insn.bank_sel && !ext_q |=>
    addr_q[7:0] == $past(insn.f) &&
    addr_q[AW-1:8] == ($past(insn.f[7]) ? {BW{1'b1}} : {BW{1'b0}}))
    else $error("common window address wrong");

  bank_ptr_a: assert property (
    state_q == saf_pkg::st_q1 && insn.op == `SAF_OPCODE &&
    insn.bank_sel |=> addr_q == {$past(bank_q), $past(insn.f)})
    else $error("banked address wrong");

  borrow_zero_a: assert property (
    state_q == saf_pkg::st_q3 |=>
    calc_q.c == (opnd_q >= acc_q) && calc_q.z == (opnd_q == acc_q) &&
    calc_q.n == res_q[7] && res_q == 8'(opnd_q - acc_q))
    else $error("borrow, zero or msb flag wrong");

  nibble_sign_a: assert property (
    state_q == saf_pkg::st_q3 |=>
    calc_q.nib == (opnd_q[3:0] >= acc_q[3:0]) &&
    calc_q.rng == ($signed(opnd_q) - $signed(acc_q) !=
    $signed({{2{res_q[7]}}, res_q})))
    else $error("nibble or signed flag wrong");

  flags_only_a: assert property (
    state_q == saf_pkg::st_q4 |=> flags_q == $past(calc_q))
    else $error("status not updated from result");

  bus_stall_a: assert property (
    busy && req |-> avs_waitrequest && !wr_do)
    else $error("access accepted while busy");

endmodule : saf_core

// ==== pkg/saf_core_regs.svh ====
`ifndef SAF_CORE_REGS_SVH
`define SAF_CORE_REGS_SVH

// register byte offsets on the avalon slave
`define SAF_OFF_CTRL 5'h00
`define SAF_OFF_INSN 5'h04
`define SAF_OFF_ACC 5'h08
`define SAF_OFF_BANK 5'h0c
`define SAF_OFF_STATUS 5'h10
`define SAF_OFF_INDEX 5'h14
`define SAF_OFF_MADDR 5'h18
`define SAF_OFF_MDATA 5'h1c

// control register bits
`define SAF_CTRL_GO 0
`define SAF_CTRL_EXT 1

// status register bits
`define SAF_ST_BUSY 5
`define SAF_ST_BAD 6

// instruction encoding
`define SAF_OPCODE 6'h17
`define SAF_ILO_MAX 8'h5f
`define SAF_ACC_SPLIT 8'h80

// reset values
`define SAF_RST_BYTE 8'h00
`define SAF_RST_INSN 16'h0000

`endif

// ==== pkg/saf_pkg.sv ====
package saf_pkg;

  // status flags, bit 4 down to bit 0 of the status register
  typedef struct packed {
    logic n;   // msb_set_flag
    logic rng; // signed_range_flag
    logic z;   // result_null_flag
    logic nib; // low_nibble_borrow_flag
    logic c;   // borrow_inverse_flag
  } saf_flags_t;

  // instruction word fields
  typedef struct packed {
    logic [5:0] op;   // opcode
    logic dest;       // target_sel_bit
    logic bank_sel;   // memory_pick_flg
    logic [7:0] f;    // operand_location
  } saf_insn_t;

  // instruction phases
  typedef enum logic [2:0] {
    st_idle,
    st_q1,
    st_q2,
    st_q3,
    st_q4
  } saf_state_t;

endpackage : saf_pkg

// ==== sim/saf_tb.sv ====
`timescale 1ns/1ps
`include "saf_core_regs.svh"

// one compare: counts it, reports a mismatch at once
`define CHK(a, b) begin \
  checks_done++; \
  if ((a) !== (b)) begin \
    miscompares++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); \
  end \
end

module tb;
  // one instruction case with the byte address it must touch
  typedef struct {
    logic [7:0] w;  // accumulator before
    logic [7:0] fv;  // file value before
    logic [7:0] f;  // operand_location
    logic d;  // target_sel_bit
    logic a;  // memory_pick_flg
    logic e;  // extended set enable
    logic [1:0] bk;  // bank_pointer
    logic [9:0] ad;  // expected memory byte address
  } saf_tb_row_t;

  logic clk = 1'b0;  // 200 mhz clock
  logic rst = 1'b1;  // async reset, active high
  logic [4:0] avs_address = 5'h00;  // byte address
  logic avs_read = 1'b0;  // read request
  logic avs_write = 1'b0;  // write request
  logic [31:0] avs_writedata = 32'h0;  // write data
  logic [3:0] avs_byteenable = 4'hf;  // all lanes on
  logic [31:0] avs_readdata;  // read data
  logic avs_waitrequest;  // stall
  int miscompares = 0;  // mismatches
  int checks_done = 0;  // compares made
  int waits;  // stall cycles of the last access
  logic [31:0] rv;  // last read value
  logic [7:0] r;  // expected result
  logic [4:0] fl;  // expected flags
  saf_tb_row_t rows [7];  // ordinary cases

  // half period of 2.5 ns
  always #2.5 clk = ~clk;

  saf_core #(.BANKS(4)) dut (
    .clk(clk),
    .rst(rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest)
  );

  // verdict and end of run
  task automatic results();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  // one avalon access, held until waitrequest is seen low
  task automatic acc(input logic wr, input logic [4:0] ad,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= ad;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= wd;
    // sample waitrequest and read data at the rising edge itself
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 60);
    if (avs_waitrequest !== 1'b0) begin
      miscompares++;
      results();
    end
    rv = avs_readdata;
    waits = n - 1;
    // release only after the completing edge
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : acc

  // expected flags {n, rng, z, nib, c} of fv minus w
  function automatic logic [4:0] flg(input logic [7:0] fv, w);
    logic [7:0] d;
    d = fv - w;
    flg = {d[7], (fv[7] != w[7]) && (d[7] != fv[7]), d == 8'h00,
           fv[3:0] >= w[3:0], fv >= w};
  endfunction : flg

  // main sequence
  initial begin
    rows = '{
      '{8'h02, 8'h03, 8'h10, 1'b1, 1'b1, 1'b0, 2'h1, 10'h110},
      '{8'h02, 8'h02, 8'h10, 1'b0, 1'b1, 1'b0, 2'h2, 10'h210},
      '{8'h02, 8'h01, 8'h20, 1'b1, 1'b0, 1'b0, 2'h2, 10'h020},
      '{8'h01, 8'h80, 8'h90, 1'b1, 1'b0, 1'b0, 2'h1, 10'h390},
      '{8'hff, 8'h7f, 8'h5f, 1'b0, 1'b0, 1'b1, 2'h0, 10'h09f},
      '{8'h01, 8'h10, 8'h60, 1'b1, 1'b0, 1'b1, 2'h0, 10'h060},
      '{8'h0f, 8'hf0, 8'hff, 1'b1, 1'b1, 1'b1, 2'h3, 10'h3ff}};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // reset values and a plain single wait cycle
    acc(1'b0, `SAF_OFF_ACC, 32'h0);
    `CHK(rv, 32'h0)
    `CHK(waits, 1)
    acc(1'b0, `SAF_OFF_STATUS, 32'h0);
    `CHK(rv, 32'h0)
    acc(1'b1, `SAF_OFF_INDEX, 32'h40);
    // table of ordinary instruction cases
    foreach (rows[i]) begin
      r = rows[i].fv - rows[i].w;
      fl = flg(rows[i].fv, rows[i].w);
      acc(1'b1, `SAF_OFF_MADDR, {22'h0, rows[i].ad});
      acc(1'b1, `SAF_OFF_MDATA, {24'h0, rows[i].fv});
      acc(1'b1, `SAF_OFF_ACC, {24'h0, rows[i].w});
      acc(1'b1, `SAF_OFF_BANK, {30'h0, rows[i].bk});
      acc(1'b1, `SAF_OFF_STATUS, {27'h0, ~fl});
      acc(1'b1, `SAF_OFF_INSN, {16'h0, `SAF_OPCODE, rows[i].d,
                                 rows[i].a, rows[i].f});
      acc(1'b1, `SAF_OFF_CTRL, {30'h0, rows[i].e, 1'b1});
      acc(1'b0, `SAF_OFF_STATUS, 32'h0);
      `CHK(rv, {27'h0, fl})
      `CHK(waits <= 6, 1'b1)
      acc(1'b0, `SAF_OFF_ACC, 32'h0);
      `CHK(rv[7:0], rows[i].d ? rows[i].w : r)
      acc(1'b0, `SAF_OFF_MDATA, 32'h0);
      `CHK(rv[7:0], rows[i].d ? r : rows[i].fv)
    end
    // last row left the extended set on
    acc(1'b0, `SAF_OFF_CTRL, 32'h0);
    `CHK(rv, 32'h2)
    // a neighbouring opcode is refused and writes nothing
    acc(1'b1, `SAF_OFF_ACC, 32'h33);
    acc(1'b1, `SAF_OFF_INSN, 32'h5a10);
    acc(1'b1, `SAF_OFF_CTRL, 32'h1);
    acc(1'b0, `SAF_OFF_STATUS, 32'h0);
    `CHK(rv[6:5], 2'b10)
    acc(1'b0, `SAF_OFF_ACC, 32'h0);
    `CHK(rv[7:0], 8'h33)
    acc(1'b0, `SAF_OFF_INSN, 32'h0);
    `CHK(rv, 32'h5a10)
    // low lane only: the upper instruction byte must stay
    avs_byteenable <= 4'h1;
    acc(1'b1, `SAF_OFF_INSN, 32'hffff);
    avs_byteenable <= 4'hf;
    acc(1'b0, `SAF_OFF_INSN, 32'h0);
    `CHK(rv, 32'h5aff)
    acc(1'b1, `SAF_OFF_STATUS, 32'h40);
    acc(1'b0, `SAF_OFF_STATUS, 32'h0);
    `CHK(rv[6], 1'b0)
    // second reset in mid-run clears the accumulator
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    acc(1'b0, `SAF_OFF_ACC, 32'h0);
    `CHK(rv, 32'h0)
    results();
  end
endmodule : tb
